// >>> core/gpa_top.sv
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Behaviour
// - pin 1 time base codes 0..3 select 16, 64, 256, 1024 clock units
// - pin 0 time base codes 0..3 select 16, 64, 256, 1024 clock units
// - spare bits read back as written and steer nothing
// - pin 1 as output drives its output value bit
// - pin 0 as output drives its output value bit
// - direction bit 0 makes a pin an input, 1 an output
// - format bit on an input selects the pwm decoded level
// - pin 0 output is always static, never pwm
module gpa_top (
  // clock, reset, enable
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  input  wire logic                         ce,
  // register port
  input  wire logic [gpa_pkg::ADDR_W-1:0]   addr,
  input  wire logic [gpa_pkg::DATA_W-1:0]   wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output wire logic [gpa_pkg::DATA_W-1:0]   rdata,
  // group a pins
  input  wire logic [gpa_pkg::NPIN-1:0]     group_a_pin_in,
  output wire logic [gpa_pkg::NPIN-1:0]     group_a_pin_out,
  output wire logic [gpa_pkg::NPIN-1:0]     group_a_pin_oe,
  // logic level seen on each pin
  output wire logic [gpa_pkg::NPIN-1:0]     pin_level
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [gpa_pkg::DATA_W-1:0]               gpio_group_a_config_r;
  logic [gpa_pkg::DATA_W-1:0]               gpio_group_a_config_nxt;
  logic [gpa_pkg::DATA_W-1:0]               rdata_r;
  logic [gpa_pkg::DATA_W-1:0]               rdata_nxt;
  logic [gpa_pkg::NPIN-1:0]                 level_r;
  logic [gpa_pkg::NPIN-1:0]                 level_nxt;
  logic [gpa_pkg::NPIN-1:0]                 dir;
  logic [gpa_pkg::NPIN-1:0]                 fmt;
  logic [gpa_pkg::NPIN-1:0]                 out_val;
  logic [gpa_pkg::NPIN-1:0]                 dec_level;
  logic [gpa_pkg::NPIN-1:0][gpa_pkg::TB_W-1:0] tb_sel;
  logic                                     cfg_wr;
  logic                                     cfg_rd;
  logic                                     stat_rd;

  gpa_dec_if dif [gpa_pkg::NPIN] ();

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign cfg_wr  = wr && (addr == gpa_pkg::CFG_ADDR);
  assign cfg_rd  = rd && (addr == gpa_pkg::CFG_ADDR);
  assign stat_rd = rd && (addr == gpa_pkg::STAT_ADDR);

  // ----------------------------------------------------------------
  // per-pin fields and decoders
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < gpa_pkg::NPIN; i++) begin : g_pin
      assign dir[i]     = gpio_group_a_config_r[gpa_pkg::DIR_BIT + i];
      assign fmt[i]     = gpio_group_a_config_r[gpa_pkg::FMT_BIT + i];
      assign out_val[i] = gpio_group_a_config_r[gpa_pkg::DAT_BIT + i];
      assign tb_sel[i]  =
        gpio_group_a_config_r[gpa_pkg::TB_LO + gpa_pkg::TB_W*i +:
                              gpa_pkg::TB_W];

      // decoder only runs for a pwm-format input
      assign dif[i].en     = fmt[i] && !dir[i];
      assign dif[i].tb_sel = tb_sel[i];
      assign dif[i].pin_in = group_a_pin_in[i];
      assign dec_level[i]  = dif[i].level;

      gpa_pwm_dec u_dec (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .dif     (dif[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_comb begin
    gpio_group_a_config_nxt = gpio_group_a_config_r;
    if (cfg_wr) begin
      // spare bits stored like any other, reserved bits forced low
      gpio_group_a_config_nxt = wdata & gpa_pkg::CFG_WMASK;
    end
    rdata_nxt = gpa_pkg::ZERO_WORD;
    if (cfg_rd) begin
      rdata_nxt = gpio_group_a_config_r;
    end else if (stat_rd) begin
      rdata_nxt[gpa_pkg::NPIN-1:0] = level_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gpio_group_a_config_r <= gpa_pkg::CFG_RESET;
      rdata_r               <= gpa_pkg::ZERO_WORD;
    end else if (ce) begin
      gpio_group_a_config_r <= gpio_group_a_config_nxt;
      rdata_r               <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

  // ----------------------------------------------------------------
  // input level selection
  // ----------------------------------------------------------------
  always_comb begin
    level_nxt = level_r;
    for (int i = 0; i < gpa_pkg::NPIN; i++) begin
      if (dir[i]) begin
        // output pins read back the level they drive
        level_nxt[i] = out_val[i];
      end else if (fmt[i]) begin
        level_nxt[i] = dec_level[i];
      end else begin
        level_nxt[i] = group_a_pin_in[i];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_r <= '0;
    end else if (ce) begin
      level_r <= level_nxt;
    end
  end

  assign pin_level = level_r;

  // ----------------------------------------------------------------
  // pin drive, always static
  // ----------------------------------------------------------------
  // data and enable come straight from config flops
  assign group_a_pin_out = out_val;
  assign group_a_pin_oe  = dir;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_cfg_write;
    ce && cfg_wr;
  endsequence

  sequence s_cfg_read;
    ce && cfg_rd;
  endsequence

  AST_P0_OUT: assert property (@(posedge clk) disable iff (!reset_n)
    s_cfg_write |=> group_a_pin_out[0] == $past(wdata[gpa_pkg::DAT_BIT]) &&
                    group_a_pin_oe[0] == $past(wdata[gpa_pkg::DIR_BIT]))
    else $error("pin 0 drive does not follow config write");

  AST_P1_OUT: assert property (@(posedge clk) disable iff (!reset_n)
    s_cfg_write |=> group_a_pin_out[1] == $past(wdata[gpa_pkg::DAT_BIT+1]) &&
                    group_a_pin_oe[1] == $past(wdata[gpa_pkg::DIR_BIT+1]))
    else $error("pin 1 drive does not follow config write");

  AST_SPARE_RB: assert property (@(posedge clk) disable iff (!reset_n)
    s_cfg_write ##1 (s_cfg_read and !wr) |=>
      rdata[gpa_pkg::SPARE_HI:gpa_pkg::SPARE_LO] ==
      $past(wdata[gpa_pkg::SPARE_HI:gpa_pkg::SPARE_LO], 2))
    else $error("spare bits did not read back");

  AST_RD_ONE_CYCLE: assert property (@(posedge clk) disable iff (!reset_n)
    ce && !rd |=> rdata == gpa_pkg::ZERO_WORD)
    else $error("read data outside the answer cycle");

  AST_STATIC_IN: assert property (@(posedge clk) disable iff (!reset_n)
    ce && !dir[0] && !fmt[0] |=> pin_level[0] == $past(group_a_pin_in[0]))
    else $error("static input level not passed through");

  AST_PWM_IN: assert property (@(posedge clk) disable iff (!reset_n)
    ce && !dir[1] && fmt[1] |=> pin_level[1] == $past(dec_level[1]))
    else $error("pwm input level not selected");

  AST_TB_P1: assert property (@(posedge clk) disable iff (!reset_n)
    s_cfg_write |=>
      tb_sel[1] == $past(wdata[gpa_pkg::TB_LO+3:gpa_pkg::TB_LO+2]))
    else $error("pin 1 time base not taken");

  AST_TB_P0: assert property (@(posedge clk) disable iff (!reset_n)
    s_cfg_write |=> tb_sel[0] == $past(wdata[gpa_pkg::TB_LO+1:gpa_pkg::TB_LO]))
    else $error("pin 0 time base not taken");

  AST_P0_STATIC: assert property (@(posedge clk) disable iff (!reset_n)
    group_a_pin_oe[0] && $stable(gpio_group_a_config_r) |->
      $stable(group_a_pin_out[0]))
    else $error("pin 0 output toggles without a config change");

  AST_SPARE_INERT: assert property (@(posedge clk) disable iff (!reset_n)
    ce && cfg_wr &&
    wdata[gpa_pkg::DAT_BIT+1:gpa_pkg::DAT_BIT] ==
      gpio_group_a_config_r[gpa_pkg::DAT_BIT+1:gpa_pkg::DAT_BIT] &&
    wdata[gpa_pkg::FMT_BIT+1:gpa_pkg::TB_LO] ==
      gpio_group_a_config_r[gpa_pkg::FMT_BIT+1:gpa_pkg::TB_LO] |=>
      $stable(group_a_pin_out) && $stable(group_a_pin_oe) &&
      $stable(tb_sel) && $stable(fmt))
    else $error("spare bits changed other behaviour");

  AST_STAT_RB: assert property (@(posedge clk) disable iff (!reset_n)
    ce && stat_rd |=> rdata[gpa_pkg::NPIN-1:0] == $past(level_r))
    else $error("status read does not show pin levels");

  AST_P1_LEVEL: assert property (@(posedge clk) disable iff (!reset_n)
    ce && dir[1] |=> pin_level[1] == $past(out_val[1]))
    else $error("pin 1 output level not reported");

  AST_P0_LEVEL: assert property (@(posedge clk) disable iff (!reset_n)
    ce && dir[0] |=> pin_level[0] == $past(out_val[0]))
    else $error("pin 0 output level not reported");

endmodule : gpa_top

// >>> core/gpa_pkg.sv
package gpa_pkg;

  // ----------------------------------------------------------------
  // bus and map
  // ----------------------------------------------------------------
  localparam int                ADDR_W    = 8;
  localparam int                DATA_W    = 16;
  localparam int                NPIN      = 2;
  localparam logic [ADDR_W-1:0] CFG_ADDR  = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h01;
  localparam logic [DATA_W-1:0] CFG_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] CFG_WMASK = 16'h0fff;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // field positions, pin n at base + n (time base at base + 2n)
  // ----------------------------------------------------------------
  localparam int DAT_BIT  = 0;
  localparam int SPARE_LO = 2;
  localparam int SPARE_HI = 3;
  localparam int TB_LO    = 4;
  localparam int TB_W     = 2;
  localparam int DIR_BIT  = 8;
  localparam int FMT_BIT  = 10;

  // ----------------------------------------------------------------
  // pwm decoder timing, terminal counts of the time-base prescaler
  // ----------------------------------------------------------------
  localparam int               PRE_W    = 10;
  localparam int               CNT_W    = 8;
  localparam logic [PRE_W-1:0] TC_16    = 10'h00f;
  localparam logic [PRE_W-1:0] TC_64    = 10'h03f;
  localparam logic [PRE_W-1:0] TC_256   = 10'h0ff;
  localparam logic [PRE_W-1:0] TC_1024  = 10'h3ff;
  localparam logic [PRE_W-1:0] PRE_ZERO = 10'h000;
  localparam logic [PRE_W-1:0] PRE_ONE  = 10'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
  localparam logic [CNT_W-1:0] CNT_MAX  = 8'hff;

  typedef enum logic [1:0] {
    GPA_WAIT = 2'b01,
    GPA_MEAS = 2'b10
  } gpa_dec_st_t;

  function automatic logic [PRE_W-1:0] gpa_tb_tc(
    input logic [TB_W-1:0] sel
  );
    logic [PRE_W-1:0] tc;
    case (sel)
      2'h0:    tc = TC_16;
      2'h1:    tc = TC_64;
      2'h2:    tc = TC_256;
      default: tc = TC_1024;
    endcase
    return tc;
  endfunction : gpa_tb_tc

endpackage : gpa_pkg

// >>> core/gpa_dec_if.sv
`timescale 1ns/1ps
interface gpa_dec_if;
  logic                    en;
  logic [gpa_pkg::TB_W-1:0] tb_sel;
  logic                    pin_in;
  logic                    level;

  modport dec (input en, input tb_sel, input pin_in, output level);
  modport cfg (output en, output tb_sel, output pin_in, input level);
endinterface : gpa_dec_if

// >>> core/gpa_pwm_dec.sv
`timescale 1ns/1ps
module gpa_pwm_dec (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // link to the config logic
  gpa_dec_if.dec   dif
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  gpa_pkg::gpa_dec_st_t            st_r;
  gpa_pkg::gpa_dec_st_t            st_nxt;
  logic [gpa_pkg::PRE_W-1:0]       pre_r;
  logic [gpa_pkg::PRE_W-1:0]       pre_nxt;
  logic [gpa_pkg::CNT_W-1:0]       hi_r;
  logic [gpa_pkg::CNT_W-1:0]       hi_nxt;
  logic [gpa_pkg::CNT_W-1:0]       lo_r;
  logic [gpa_pkg::CNT_W-1:0]       lo_nxt;
  logic                            pin_d_r;
  logic                            pin_d_nxt;
  logic                            level_r;
  logic                            level_nxt;
  logic [gpa_pkg::PRE_W-1:0]       tc;
  logic                            tick;
  logic                            rise;
  logic                            sat;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    tc        = gpa_pkg::gpa_tb_tc(dif.tb_sel);
    // >= so a shrinking time base cannot strand the prescaler
    tick      = dif.en && (pre_r >= tc);
    rise      = dif.en && dif.pin_in && !pin_d_r;
    sat       = (hi_r == gpa_pkg::CNT_MAX) || (lo_r == gpa_pkg::CNT_MAX);
    pre_nxt   = (!dif.en || tick) ? gpa_pkg::PRE_ZERO
                                  : pre_r + gpa_pkg::PRE_ONE;
    pin_d_nxt = dif.pin_in;
    st_nxt    = st_r;
    hi_nxt    = hi_r;
    lo_nxt    = lo_r;
    level_nxt = level_r;
    if (!dif.en) begin
      st_nxt = gpa_pkg::GPA_WAIT;
      hi_nxt = gpa_pkg::CNT_ZERO;
      lo_nxt = gpa_pkg::CNT_ZERO;
    end else begin
      unique case (st_r)
        gpa_pkg::GPA_WAIT: begin
          if (rise) begin
            st_nxt = gpa_pkg::GPA_MEAS;
            hi_nxt = gpa_pkg::CNT_ZERO;
            lo_nxt = gpa_pkg::CNT_ZERO;
          end
        end
        gpa_pkg::GPA_MEAS: begin
          if (rise) begin
            // period closed: level follows the duty cycle
            level_nxt = (hi_r > lo_r);
            hi_nxt    = gpa_pkg::CNT_ZERO;
            lo_nxt    = gpa_pkg::CNT_ZERO;
          end else if (sat) begin
            // no edges any more: fall back to the static level
            level_nxt = dif.pin_in;
            st_nxt    = gpa_pkg::GPA_WAIT;
          end else if (tick) begin
            if (dif.pin_in) begin
              hi_nxt = hi_r + gpa_pkg::CNT_ONE;
            end else begin
              lo_nxt = lo_r + gpa_pkg::CNT_ONE;
            end
          end
        end
        default: begin
          st_nxt = gpa_pkg::GPA_WAIT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r    <= gpa_pkg::GPA_WAIT;
      pre_r   <= gpa_pkg::PRE_ZERO;
      hi_r    <= gpa_pkg::CNT_ZERO;
      lo_r    <= gpa_pkg::CNT_ZERO;
      pin_d_r <= 1'b0;
      level_r <= 1'b0;
    end else if (ce) begin
      st_r    <= st_nxt;
      pre_r   <= pre_nxt;
      hi_r    <= hi_nxt;
      lo_r    <= lo_nxt;
      pin_d_r <= pin_d_nxt;
      level_r <= level_nxt;
    end
  end

  assign dif.level = level_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_period_end;
    ce && dif.en && st_r == gpa_pkg::GPA_MEAS && rise;
  endsequence

  AST_TICK_GAP: assert property (@(posedge clk) disable iff (!reset_n)
    ce && tick |=> !tick [*8])
    else $error("time base tick repeated too soon");
  AST_PRE_RESTART: assert property (@(posedge clk) disable iff (!reset_n)
    ce && tick |=> pre_r == gpa_pkg::PRE_ZERO)
    else $error("prescaler did not restart after tick");
  AST_LEVEL_DUTY: assert property (@(posedge clk) disable iff (!reset_n)
    s_period_end |=> level_r == $past(hi_r > lo_r))
    else $error("decoded level does not follow duty cycle");
  AST_NO_EN_WAIT: assert property (@(posedge clk) disable iff (!reset_n)
    ce && !dif.en |=> st_r == gpa_pkg::GPA_WAIT && hi_r == gpa_pkg::CNT_ZERO)
    else $error("decoder active while pwm input is off");

endmodule : gpa_pwm_dec

// >>> verif/gpa_pin_model.sv
`timescale 1ns/1ps
module gpa_pin_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // waveform control
  input  wire logic        pwm_on,
  input  wire logic [1:0]  level_set,
  input  wire logic [15:0] hi_cyc,
  input  wire logic [15:0] lo_cyc,
  // external drive, both pins
  output logic      [1:0]  ext_val
);
  // ----------------------------------------------------------------
  // low phase then high phase, rising edge once per period
  // ----------------------------------------------------------------
  logic [15:0] phase_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r <= 16'h0000;
      ext_val <= 2'h0;
    end else if (pwm_on) begin
      if (phase_r + 16'h0001 >= lo_cyc + hi_cyc) begin
        phase_r <= 16'h0000;
      end else begin
        phase_r <= phase_r + 16'h0001;
      end
      ext_val <= {2{phase_r >= lo_cyc}};
    end else begin
      phase_r <= 16'h0000;
      ext_val <= level_set;
    end
  end
endmodule : gpa_pin_model

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic                         clk;
  logic                         reset_n;
  logic                         ce;
  logic                         wr;
  logic                         rd;
  logic                         pwm_on;
  logic [gpa_pkg::ADDR_W-1:0]   addr;
  logic [gpa_pkg::DATA_W-1:0]   wdata;
  logic [gpa_pkg::DATA_W-1:0]   rdata;
  logic [15:0]                  hi_cyc;
  logic [15:0]                  lo_cyc;
  logic [15:0]                  cfg;
  logic [1:0]                   pin_in;
  logic [1:0]                   pin_out;
  logic [1:0]                   pin_oe;
  logic [1:0]                   pin_level;
  logic [1:0]                   ext_val;
  logic [1:0]                   level_set;
  int                           fail_count;
  int                           n_compared;
  int                           t;

  // ----------------------------------------------------------------
  // clock, pin wire, instances
  // ----------------------------------------------------------------
  always #10 clk = ~clk;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);

  gpa_top gpa_top_inst (.clk(clk), .reset_n(reset_n), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .group_a_pin_in(pin_in), .group_a_pin_out(pin_out),
    .group_a_pin_oe(pin_oe), .pin_level(pin_level));

  gpa_pin_model gpa_pin_model_inst (.clk(clk), .reset_n(reset_n),
    .pwm_on(pwm_on), .level_set(level_set), .hi_cyc(hi_cyc),
    .lo_cyc(lo_cyc), .ext_val(ext_val));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] act, input logic [15:0] exp);
    n_compared++;
    if (act !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, act, exp);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wreg

  task automatic rreg(input logic [7:0] a, input logic [15:0] exp);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
    @(posedge clk);
  endtask : rreg

  task automatic wrrd(input logic [7:0] a, input logic [15:0] d,
                      input logic [15:0] exp);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
    @(posedge clk);
  endtask : wrrd

  task automatic pchk(input logic [1:0] oe, input logic [1:0] lvl);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({14'h0, pin_oe}, {14'h0, oe});
    chk({14'h0, pin_level}, {14'h0, lvl});
    @(posedge clk);
  endtask : pchk

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    $display("[ERR] %0t run did not finish", $time);
    conclude();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk        = 1'b0;
    reset_n    = 1'b0;
    ce         = 1'b1;
    wr         = 1'b0;
    rd         = 1'b0;
    addr       = 8'h00;
    wdata      = 16'h0000;
    pwm_on     = 1'b0;
    level_set  = 2'h0;
    hi_cyc     = 16'h0010;
    lo_cyc     = 16'h0010;
    fail_count = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rreg(gpa_pkg::CFG_ADDR, gpa_pkg::CFG_RESET);
    pchk(2'b00, 2'b00);
    chk({14'h0, pin_out}, 16'h0000);
    $display("test reset done");
    wreg(gpa_pkg::CFG_ADDR, 16'hffff);
    rreg(gpa_pkg::CFG_ADDR, gpa_pkg::CFG_WMASK);
    pchk(2'b11, 2'b11);
    chk({14'h0, pin_out}, 16'h0003);
    wreg(gpa_pkg::STAT_ADDR, 16'h0000);
    rreg(gpa_pkg::CFG_ADDR, gpa_pkg::CFG_WMASK);
    rreg(8'h05, gpa_pkg::ZERO_WORD);
    ce <= 1'b0;
    wreg(gpa_pkg::CFG_ADDR, gpa_pkg::ZERO_WORD);
    ce <= 1'b1;
    rreg(gpa_pkg::CFG_ADDR, gpa_pkg::CFG_WMASK);
    $display("test access done");
    for (int v = 0; v < 4; v++) begin
      wreg(gpa_pkg::CFG_ADDR, {14'h00c0, 2'(v)});
      pchk(2'b11, 2'(v));
      chk({14'h0, pin_out}, {14'h0, 2'(v)});
      rreg(gpa_pkg::STAT_ADDR, {14'h0, 2'(v)});
    end
    $display("test output done");
    level_set <= 2'b01;
    wreg(gpa_pkg::CFG_ADDR, 16'h0003);
    pchk(2'b00, 2'b01);
    wrrd(gpa_pkg::CFG_ADDR, 16'h000f, 16'h000f);
    pchk(2'b00, 2'b01);
    level_set <= 2'b10;
    pchk(2'b00, 2'b10);
    rreg(gpa_pkg::CFG_ADDR, 16'h000f);
    $display("test input done");
    level_set <= 2'b00;
    for (int c = 0; c < 4; c++) begin
      t   = 16 << (2 * c);
      cfg = {8'h0c, 2'(c), 2'(c), 4'h0};
      wreg(gpa_pkg::CFG_ADDR, 16'h0000);
      wreg(gpa_pkg::CFG_ADDR, cfg);
      // low-dominant duty on one pass so the level must change
      hi_cyc <= 16'(((c == 1) ? 2 : 6) * t);
      lo_cyc <= 16'(((c == 1) ? 6 : 2) * t);
      pwm_on <= 1'b1;
      repeat (24 * t + 10) @(posedge clk);
      chk({14'h0, pin_level}, (c == 1) ? 16'h0000 : 16'h0003);
      rreg(gpa_pkg::CFG_ADDR, cfg);
      pwm_on <= 1'b0;
    end
    $display("test duty done");
    wreg(gpa_pkg::CFG_ADDR, 16'h0000);
    wreg(gpa_pkg::CFG_ADDR, 16'h0c40);
    hi_cyc <= 16'd128;
    lo_cyc <= 16'd384;
    pwm_on <= 1'b1;
    repeat (1546) @(posedge clk);
    chk({14'h0, pin_level}, 16'h0000);
    pwm_on    <= 1'b0;
    level_set <= 2'b00;
    repeat (128) @(posedge clk);
    level_set <= 2'b11;
    repeat (4000) @(posedge clk);
    chk({14'h0, pin_level}, 16'h0000);
    repeat (192) @(posedge clk);
    chk({14'h0, pin_level}, 16'h0001);
    repeat (11808) @(posedge clk);
    chk({14'h0, pin_level}, 16'h0001);
    repeat (768) @(posedge clk);
    chk({14'h0, pin_level}, 16'h0003);
    $display("test time base done");
    conclude();
  end
endmodule : tb
